/* script_fetch_pkg.sv */
// Constants, register map and state type of the script fetch sequencer
package script_fetch_pkg;

	// ------------------------------------------------------------
	// Register offsets on the register port
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_ODL  = 8'h54;
	localparam logic [7:0] OFF_BDL  = 8'h58;
	localparam logic [7:0] OFF_SCRB = 8'h5c;
	localparam logic [7:0] OFF_SPTR = 8'h60;
	localparam logic [7:0] OFF_STAT = 8'h64;

	// ------------------------------------------------------------
	// Instruction encoding (top byte of the first word)
	// ------------------------------------------------------------
	localparam logic [1:0] TYPE_BMOVE = 2'h0;
	localparam logic [1:0] TYPE_IORW  = 2'h1;
	localparam logic [1:0] TYPE_XFER  = 2'h2;
	localparam logic [1:0] TYPE_MMOVE = 2'h3;
	localparam int         BIT_TYPE_HI = 7;
	localparam int         BIT_TYPE_LO = 6;
	localparam int         BIT_IND     = 5;
	localparam int         BIT_REGWR   = 4;
	localparam int         BIT_INTR    = 3;
	localparam int         BIT_DIR     = 0;

	// ------------------------------------------------------------
	// Fetch word slots, sizes and addresses
	// ------------------------------------------------------------
	localparam logic [1:0]  W_CMD   = 2'h0;
	localparam logic [1:0]  W_OPND  = 2'h1;
	localparam logic [1:0]  W_THIRD = 2'h2;
	localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
	localparam logic [23:0] BEAT_BYTES  = 24'h00_0004;
	localparam logic [23:0] BURST_BYTES = 24'h00_0010;
	localparam logic [31:0] SCRB_ALIAS  = 32'h0000_005c;
	localparam logic [31:0] RESET_WORD  = 32'h0000_0000;

	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_FETCH = 7'h02,
		S_EXEC  = 7'h04,
		S_WAITF = 7'h08,
		S_BURST = 7'h10,
		S_MMRD  = 7'h20,
		S_HALT  = 7'h40
	} state_t;

endpackage

/* script_fetch_dma_sequencer.sv */
// Script fetch and block move DMA sequencer with SCSI data registers
//
// Contract
// - Latch reaches SCSI data lines only while assert-data-bus is set.
// - Outgoing SCSI data passes through latch; latch feeds FIFO in test.
// - Bus data lines read live bus, inverted to active high.
// - Scratch B changes only by CPU, register writes, memory moves.
// - Never fetch instructions from the scratch B address.
// - Each instruction is two or three 32-bit words.
// - Device fetches instructions as bus master into its registers.
// - Run until interrupt instruction or hardware error raises interrupt.
// - After interrupt halt until host writes the script pointer.
// - Word one to command/count, two to operand, three to shadow.
// - Indirect instructions add extra 32-bit fetch cycles.
// - Pointer write requests bus and fetches from that address.
// - Top byte is opcode; block move has count and address.
// - Wait for FIFO room or data of one burst (up to 16 bytes) before a burst.
// - Burst, count down, advance address, release bus, wait FIFO.
// - Count zero: release bus, then fetch the next instruction.
// - Loopback exchanges latch data internally with the read path.
// - Low level mode stops DMA and instruction execution.
// - Test write: low byte write to latch pushes latch into FIFO.
`timescale 1ns/1ps

module script_fetch_dma_sequencer (
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        ARST_N,
	// Register port
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [3:0]  REG_BE,
	input  wire logic [31:0] REG_WDATA,
	output logic      [31:0] REG_RDATA,
	// Mode controls
	input  wire logic        ASSERT_DATA_BUS,
	input  wire logic        LOW_LEVEL_MODE,
	input  wire logic        FIFO_TEST_WRITE,
	input  wire logic        LOOPBACK_MODE,
	// SCSI data pins and SCSI FIFO side
	input  wire logic [7:0]  SD_I,
	output logic      [7:0]  SD_O,
	output logic             SD_OE,
	input  wire logic        SEND_LOAD,
	input  wire logic [7:0]  SEND_DATA,
	output logic             SF_PUSH,
	output logic      [7:0]  SF_DATA,
	// Host bus master
	output logic             BUS_REQ,
	input  wire logic        BUS_GNT,
	output logic      [31:0] MEM_ADDR,
	output logic             MEM_RD,
	output logic             MEM_WR,
	output logic      [31:0] MEM_WDATA,
	input  wire logic [31:0] MEM_RDATA,
	input  wire logic        MEM_ACK,
	input  wire logic        MEM_ERR,
	// DMA FIFO
	input  wire logic [7:0]  DF_FREE,
	input  wire logic [7:0]  DF_USED,
	output logic             DF_PUSH,
	output logic      [31:0] DF_WDATA,
	output logic             DF_POP,
	input  wire logic [31:0] DF_RDATA,
	// Host interrupt
	output logic             IRQ
);
	import script_fetch_pkg::*;

	function automatic logic [23:0] clamp(input logic [23:0] v,
		input logic [23:0] cap);
		return (v < cap) ? v : cap;
	endfunction

	state_t      state;
	logic [31:0] script_ptr;
	logic [31:0] mem_addr;
	logic [31:0] instruction_operand;
	logic [31:0] shadow;
	logic [31:0] scratch_pad_b;
	logic [31:0] wbuf;
	logic [7:0]  instruction_command;
	logic [23:0] byte_counter;
	logic [23:0] burst_left;
	logic [7:0]  output_data_latch;
	logic [1:0]  widx;
	logic [1:0]  need;
	logic        wloaded;
	logic        err_flag;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic        run;
	logic        ptr_wr;
	logic        scr_wr;
	logic        odl_wr;
	logic        granted;
	logic        ack;
	logic        is_send;
	logic        indirect;
	logic        fifo_ready;
	logic        instr_scr_wr;
	logic        mm_scr_wr;
	logic [1:0]  itype;
	logic [23:0] beat;
	logic [23:0] chunk;
	logic [7:0]  bus_lines;

	assign run     = !LOW_LEVEL_MODE;
	assign ptr_wr  = REG_WR && REG_ADDR == OFF_SPTR;
	assign scr_wr  = REG_WR && REG_ADDR == OFF_SCRB;
	assign odl_wr  = REG_WR && REG_ADDR == OFF_ODL && REG_BE[0];
	assign granted = run && BUS_GNT;
	assign ack     = granted && MEM_ACK && (MEM_RD || MEM_WR);
	assign itype   = instruction_command[BIT_TYPE_HI:BIT_TYPE_LO];
	assign is_send = !instruction_command[BIT_DIR];
	assign indirect = instruction_command[BIT_IND] &&
		(itype == TYPE_BMOVE || itype == TYPE_IORW);
	assign beat    = clamp(byte_counter, BEAT_BYTES);
	assign chunk   = clamp(byte_counter, BURST_BYTES);
	assign fifo_ready = is_send ? 24'(DF_FREE) >= chunk
		: 24'(DF_USED) >= chunk;
	assign instr_scr_wr = run && state == S_EXEC &&
		itype == TYPE_IORW && instruction_command[BIT_REGWR];
	assign mm_scr_wr = state == S_MMRD && ack && !MEM_ERR;

	// ------------------------------------------------------------
	// Bus master and pin outputs
	// ------------------------------------------------------------
	assign BUS_REQ = run && (state == S_FETCH || state == S_BURST ||
		state == S_MMRD);
	assign MEM_RD  = granted && ((state == S_FETCH &&
		mem_addr != SCRB_ALIAS) || state == S_MMRD ||
		(state == S_BURST && is_send));
	assign MEM_WR  = granted && state == S_BURST && !is_send && wloaded;
	assign DF_POP  = run && state == S_BURST && !is_send && !wloaded;
	assign MEM_ADDR  = mem_addr;
	assign MEM_WDATA = wbuf;
	assign IRQ     = state == S_HALT;
	assign SD_O    = ~output_data_latch;
	assign SD_OE   = ASSERT_DATA_BUS;
	assign bus_lines = LOOPBACK_MODE ? output_data_latch
		: ~SD_I;

	// ------------------------------------------------------------
	// Fetch and execute engine
	// ------------------------------------------------------------
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= S_IDLE;
			script_ptr <= RESET_WORD;
			mem_addr <= RESET_WORD;
			instruction_operand <= RESET_WORD;
			shadow <= RESET_WORD;
			instruction_command <= '0;
			byte_counter <= '0;
			burst_left <= '0;
			widx <= W_CMD;
			need <= W_OPND;
			wloaded <= 1'b0;
			wbuf <= RESET_WORD;
			err_flag <= 1'b0;
			DF_PUSH <= 1'b0;
			DF_WDATA <= RESET_WORD;
		end else begin
			DF_PUSH <= 1'b0;
			if (ptr_wr) begin
				// Start or resume from the written address
				script_ptr <= REG_WDATA;
				mem_addr <= REG_WDATA;
				widx <= W_CMD;
				err_flag <= 1'b0;
				state <= S_FETCH;
			end else if (ack && MEM_ERR) begin
				err_flag <= 1'b1;
				state <= S_HALT;
			end else if (run) begin
				unique case (state)
				S_IDLE, S_HALT: begin
				end
				S_FETCH: begin
					if (mem_addr == SCRB_ALIAS) begin
						err_flag <= 1'b1;
						state <= S_HALT;
					end else if (ack) begin
						unique case (widx)
						W_CMD: begin
							{instruction_command, byte_counter} <= MEM_RDATA;
							need <= (MEM_RDATA[31:30] == TYPE_MMOVE ||
								(MEM_RDATA[29] && !MEM_RDATA[31])) ?
								W_THIRD : W_OPND;
							script_ptr <= script_ptr + WORD_BYTES;
							mem_addr <= script_ptr + WORD_BYTES;
						end
						W_OPND: begin
							instruction_operand <= MEM_RDATA;
							script_ptr <= script_ptr + WORD_BYTES;
							mem_addr <= indirect ? MEM_RDATA
								: script_ptr + WORD_BYTES;
						end
						default: begin
							if (indirect) begin
								instruction_operand <= MEM_RDATA;
							end else begin
								shadow <= MEM_RDATA;
								script_ptr <= script_ptr + WORD_BYTES;
							end
						end
						endcase
						widx <= widx + 2'h1;
						if (widx == need) begin
							state <= S_EXEC;
						end
					end
				end
				S_EXEC: begin
					widx <= W_CMD;
					mem_addr <= script_ptr;
					state <= S_FETCH;
					unique case (itype)
					TYPE_BMOVE: begin
						mem_addr <= instruction_operand;
						state <= S_WAITF;
					end
					TYPE_XFER: begin
						if (instruction_command[BIT_INTR]) begin
							state <= S_HALT;
						end
					end
					TYPE_MMOVE: begin
						if (shadow == SCRB_ALIAS) begin
							mem_addr <= instruction_operand;
							state <= S_MMRD;
						end
					end
					TYPE_IORW: begin
					end
					endcase
				end
				S_MMRD: begin
					if (ack) begin
						widx <= W_CMD;
						mem_addr <= script_ptr;
						state <= S_FETCH;
					end
				end
				S_WAITF: begin
					if (byte_counter == '0) begin
						widx <= W_CMD;
						mem_addr <= script_ptr;
						state <= S_FETCH;
					end else if (fifo_ready) begin
						burst_left <= chunk;
						state <= S_BURST;
					end
				end
				S_BURST: begin
					if (DF_POP) begin
						wbuf <= DF_RDATA;
						wloaded <= 1'b1;
					end
					if (ack) begin
						byte_counter <= byte_counter - beat;
						burst_left <= burst_left - beat;
						mem_addr <= mem_addr + WORD_BYTES;
						wloaded <= 1'b0;
						DF_PUSH <= is_send;
						DF_WDATA <= MEM_RDATA;
						if (burst_left <= beat) begin
							state <= S_WAITF;
						end
					end
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Scratch register
	// ------------------------------------------------------------
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			scratch_pad_b <= RESET_WORD;
		end else if (scr_wr) begin
			for (int i = 0; i < 4; i++) begin
				if (REG_BE[i]) begin
					scratch_pad_b[8*i +: 8] <= REG_WDATA[8*i +: 8];
				end
			end
		end else if (instr_scr_wr) begin
			scratch_pad_b <= instruction_operand;
		end else if (mm_scr_wr) begin
			scratch_pad_b <= MEM_RDATA;
		end
	end

	// ------------------------------------------------------------
	// Output data latch and SCSI FIFO test write
	// ------------------------------------------------------------
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			output_data_latch <= '0;
			SF_PUSH <= 1'b0;
			SF_DATA <= '0;
		end else begin
			if (odl_wr) begin
				output_data_latch <= REG_WDATA[7:0];
			end else if (SEND_LOAD) begin
				output_data_latch <= SEND_DATA;
			end
			SF_PUSH <= odl_wr && FIFO_TEST_WRITE;
			SF_DATA <= REG_WDATA[7:0];
		end
	end

	// ------------------------------------------------------------
	// Register read, free of side effects
	// ------------------------------------------------------------
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			REG_RDATA <= RESET_WORD;
		end else if (REG_RD) begin
			unique case (REG_ADDR)
			OFF_ODL:  REG_RDATA <= {24'h0, output_data_latch};
			OFF_BDL:  REG_RDATA <= {24'h0, bus_lines};
			OFF_SCRB: REG_RDATA <= scratch_pad_b;
			OFF_SPTR: REG_RDATA <= script_ptr;
			OFF_STAT: REG_RDATA <= {29'h0, state != S_IDLE &&
				state != S_HALT, err_flag, state == S_HALT};
			default:  REG_RDATA <= RESET_WORD;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge MCLK); endclocking
	default disable iff (!ARST_N);

	a_drive_gate: assert property (SD_OE == ASSERT_DATA_BUS &&
		(!SD_OE || SD_O == ~output_data_latch))
		else $error("data lines driven without assert bit");
	a_test_write: assert property (odl_wr && FIFO_TEST_WRITE
		|=> SF_PUSH && SF_DATA == output_data_latch)
		else $error("test write did not push latch");
	a_bdl_invert: assert property (REG_RD && REG_ADDR == OFF_BDL
		&& !LOOPBACK_MODE |=> REG_RDATA[7:0] == ~$past(SD_I))
		else $error("bus data lines not inverted live value");
	a_scratch_hold: assert property (!scr_wr && !instr_scr_wr
		&& !mm_scr_wr |=> $stable(scratch_pad_b))
		else $error("scratch changed without a source");
	a_no_scratch_fetch: assert property (state == S_FETCH
		&& MEM_RD |-> mem_addr != SCRB_ALIAS)
		else $error("fetch from scratch address");
	a_ptr_restart: assert property (ptr_wr |=> state == S_FETCH
		&& MEM_ADDR == $past(REG_WDATA) && !IRQ)
		else $error("pointer write did not start a fetch");
	a_halt_quiet: assert property (state == S_HALT && !ptr_wr
		|=> state == S_HALT && !BUS_REQ && IRQ)
		else $error("activity while halted");
	a_low_no_dma: assert property (LOW_LEVEL_MODE |-> !BUS_REQ
		&& !DF_POP ##1 !DF_PUSH)
		else $error("dma activity in low level mode");
	a_count_done: assert property (run && state == S_WAITF
		&& byte_counter == '0 && !ptr_wr |-> !BUS_REQ ##1
		state == S_FETCH && MEM_ADDR == $past(script_ptr))
		else $error("no fetch after count reached zero");
	a_burst_step: assert property (state == S_BURST && ack
		&& !MEM_ERR && !ptr_wr |=> byte_counter ==
		$past(byte_counter) - $past(beat) &&
		MEM_ADDR == $past(MEM_ADDR) + WORD_BYTES)
		else $error("burst beat did not update count and address");

endmodule

/* host_mem_model.sv */
// Host memory and bus arbiter model facing the script sequencer
`timescale 1ns/1ps

module host_mem_model (
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        ARST_N,
	// Bus master side
	input  wire logic        BUS_REQ,
	output logic             BUS_GNT,
	input  wire logic [31:0] MEM_ADDR,
	input  wire logic        MEM_RD,
	input  wire logic        MEM_WR,
	input  wire logic [31:0] MEM_WDATA,
	output logic      [31:0] MEM_RDATA,
	output logic             MEM_ACK,
	output logic             MEM_ERR,
	// Pacing and fault control
	input  wire logic [1:0]  WAIT_STATES,
	input  wire logic        FAIL
);
	logic [31:0] mem [0:63];
	logic [1:0]  waited;
	logic        cyc;
	logic        hit;

	assign cyc = BUS_GNT & (MEM_RD | MEM_WR);
	assign hit = cyc & !MEM_ACK & (waited == WAIT_STATES);
	// Undriven read lines show the inverse, never the last word
	assign MEM_RDATA = MEM_RD ? mem[MEM_ADDR[7:2]] : ~mem[MEM_ADDR[7:2]];
	assign MEM_ERR = FAIL & MEM_ACK;

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			BUS_GNT <= 1'b0;
			MEM_ACK <= 1'b0;
			waited  <= 2'h0;
		end else begin
			BUS_GNT <= BUS_REQ;
			MEM_ACK <= hit;
			waited  <= (cyc & !MEM_ACK & !hit) ? waited + 2'h1 : 2'h0;
		end
	end

	always @(posedge MCLK) begin
		if (MEM_ACK & MEM_WR)
			mem[MEM_ADDR[7:2]] <= MEM_WDATA;
	end
endmodule

/* tb.sv */
// Self-checking testbench of the script fetch DMA sequencer
`timescale 1ns/1ps

module tb;
	import script_fetch_pkg::*;
	logic mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, adb = 0, low = 0;
	logic ftw = 0, lpb = 0, send_load = 0, gnt, mrd, mwr, ack, err, fail = 0;
	logic sd_oe, sf_push, bus_req, df_push, df_pop, irq;
	logic [7:0]  reg_addr = 0, sd_i = 0, send_data = 0, sd_o, sf_data;
	logic [7:0]  df_free = 0, df_used = 0;
	logic [31:0] df_rdata = 32'h7777_0001;
	logic [3:0]  reg_be = 0;
	logic [1:0]  ws = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, maddr, mwdata, mrdata, df_wdata;
	logic [31:0] q, push_d [0:7];
	int failures = 0, samples_checked = 0, pushes = 0, sfp = 0, reqs = 0;
	int rds = 0, wrs = 0;

	always #4 mclk = ~mclk;

	script_fetch_dma_sequencer i_dut (
		.MCLK(mclk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_BE(reg_be), .REG_WDATA(reg_wdata),
		.REG_RDATA(reg_rdata), .ASSERT_DATA_BUS(adb), .LOW_LEVEL_MODE(low),
		.FIFO_TEST_WRITE(ftw), .LOOPBACK_MODE(lpb), .SD_I(sd_i), .SD_O(sd_o),
		.SD_OE(sd_oe), .SEND_LOAD(send_load), .SEND_DATA(send_data),
		.SF_PUSH(sf_push), .SF_DATA(sf_data), .BUS_REQ(bus_req),
		.BUS_GNT(gnt), .MEM_ADDR(maddr), .MEM_RD(mrd), .MEM_WR(mwr),
		.MEM_WDATA(mwdata), .MEM_RDATA(mrdata), .MEM_ACK(ack), .MEM_ERR(err),
		.DF_FREE(df_free), .DF_USED(df_used), .DF_PUSH(df_push),
		.DF_WDATA(df_wdata), .DF_POP(df_pop), .DF_RDATA(df_rdata),
		.IRQ(irq));

	host_mem_model i_mem (
		.MCLK(mclk), .ARST_N(arst_n), .BUS_REQ(bus_req), .BUS_GNT(gnt),
		.MEM_ADDR(maddr), .MEM_RD(mrd), .MEM_WR(mwr), .MEM_WDATA(mwdata),
		.MEM_RDATA(mrdata), .MEM_ACK(ack), .MEM_ERR(err),
		.WAIT_STATES(ws), .FAIL(fail));

	// ------------------------------------------------------------
	// Monitors
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		if (df_push === 1'b1) begin
			push_d[pushes[2:0]] = df_wdata;
			pushes++;
		end
		if (sf_push === 1'b1)
			sfp++;
		if (bus_req === 1'b1)
			reqs++;
		if (mrd === 1'b1)
			rds++;
		if (mwr === 1'b1 && ack === 1'b1)
			wrs++;
		// Show-ahead FIFO: next word appears after each pop
		if (df_pop === 1'b1)
			df_rdata <= df_rdata + 32'h1;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(posedge mclk);
		#1 reg_addr = a;
		reg_be = be;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge mclk);
		#1 reg_wr = 0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		#1 reg_addr = a;
		reg_rd = 1;
		@(posedge mclk);
		#1 reg_rd = 0;
		d = reg_rdata;
	endtask

	task automatic start(input logic [31:0] p);
		wr(OFF_SPTR, 4'hf, p);
	endtask

	task automatic wait_irq(input logic [2:0] st);
		repeat (600) if (irq !== 1'b1) @(posedge mclk);
		#1 chk("irq", {31'h0, irq}, 32'h1);
		rd(OFF_STAT, q);
		chk("status", {29'h0, q[2:0]}, {29'h0, st});
	endtask

	task automatic summarize;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		sd_i = 8'h3c;
		wr(OFF_ODL, 4'h1, 32'ha5);
		chk("oe_off", {31'h0, sd_oe}, 32'h0);
		adb = 1;
		#1 chk("oe_on", {31'h0, sd_oe}, 32'h1);
		chk("sd_o", {24'h0, sd_o}, 32'h5a);
		rd(OFF_ODL, q);
		chk("latch", q, 32'ha5);
		rd(OFF_BDL, q);
		chk("bdl", q, 32'hc3);
		lpb = 1;
		rd(OFF_BDL, q);
		chk("loop", q, 32'ha5);
		lpb = 0;
		chk("no_push", sfp, 0);
		@(posedge mclk);
		#1 send_data = 8'h81;
		send_load = 1;
		@(posedge mclk);
		#1 send_load = 0;
		#1 chk("send_o", {24'h0, sd_o}, 32'h7e);
		ftw = 1;
		wr(OFF_ODL, 4'h1, 32'h33);
		repeat (2) @(posedge mclk);
		#1 chk("sf_push", sfp, 1);
		chk("sf_data", {24'h0, sf_data}, 32'h33);
		ftw = 0;
		wr(OFF_SCRB, 4'hf, 32'h11223344);
		wr(OFF_SCRB, 4'h5, 32'haabbccdd);
		rd(OFF_SCRB, q);
		chk("scratch", q, 32'h11bb33dd);
		rd(8'h70, q);
		chk("unmapped", q, 32'h0);
	endtask

	task automatic t_send;
		i_mem.mem[16] = 32'h0000_0008;
		i_mem.mem[17] = 32'h0000_0080;
		i_mem.mem[18] = 32'h8800_0000;
		i_mem.mem[19] = 32'h0;
		i_mem.mem[32] = 32'hcafe_0001;
		i_mem.mem[33] = 32'hcafe_0002;
		ws = 2'h2;
		start(32'h40);
		repeat (30) @(posedge mclk);
		#1 chk("wait_push", pushes, 0);
		chk("wait_req", {31'h0, bus_req}, 32'h0);
		df_free = 8'h10;
		wait_irq(3'b001);
		chk("pushes", pushes, 2);
		chk("word0", push_d[0], 32'hcafe_0001);
		chk("word1", push_d[1], 32'hcafe_0002);
		reqs = 0;
		repeat (10) @(posedge mclk);
		chk("halted", reqs, 0);
		ws = 2'h0;
	endtask

	task automatic t_iowr;
		i_mem.mem[16] = 32'h5000_0000;
		i_mem.mem[17] = 32'h1234_5678;
		start(32'h40);
		wait_irq(3'b001);
		rd(OFF_SCRB, q);
		chk("io_scr", q, 32'h1234_5678);
	endtask

	task automatic t_low;
		low = 1;
		reqs = 0;
		start(32'h48);
		repeat (20) @(posedge mclk);
		chk("low_req", reqs, 0);
		low = 0;
		wait_irq(3'b001);
	endtask

	task automatic t_alias;
		rds = 0;
		start(SCRB_ALIAS);
		wait_irq(3'b011);
		chk("alias_rd", rds, 0);
	endtask

	task automatic t_recv;
		i_mem.mem[16] = 32'h2100_0008;
		i_mem.mem[17] = 32'h0000_00b0;
		i_mem.mem[18] = 32'h8800_0000;
		i_mem.mem[19] = 32'h0;
		i_mem.mem[44] = 32'h0000_00c0;
		wrs = 0;
		start(32'h40);
		repeat (30) @(posedge mclk);
		#1 chk("recv_wait", wrs, 0);
		df_used = 8'h10;
		wait_irq(3'b001);
		chk("recv_wrs", wrs, 2);
		chk("recv_w0", i_mem.mem[48], 32'h7777_0001);
		chk("recv_w1", i_mem.mem[49], 32'h7777_0002);
	endtask

	task automatic t_mmove;
		i_mem.mem[16] = 32'hc000_0000;
		i_mem.mem[17] = 32'h0000_00a0;
		i_mem.mem[18] = SCRB_ALIAS;
		i_mem.mem[19] = 32'h8800_0000;
		i_mem.mem[20] = 32'h0;
		i_mem.mem[40] = 32'h4b1d_2c3e;
		start(32'h40);
		wait_irq(3'b001);
		rd(OFF_SCRB, q);
		chk("mm_scr", q, 32'h4b1d_2c3e);
		rd(OFF_SPTR, q);
		chk("mm_ptr", q, 32'h0000_0054);
	endtask

	task automatic t_error;
		fail = 1;
		start(32'h40);
		wait_irq(3'b011);
		fail = 0;
	endtask

	initial begin
		repeat (3) @(posedge mclk);
		#1 arst_n = 1;
		t_regs();
		t_send();
		t_iowr();
		t_low();
		t_alias();
		t_recv();
		t_mmove();
		t_error();
		summarize();
	end

	initial begin
		#40000;
		failures++;
		summarize();
	end
endmodule
